// ===== rtl/sdc_pkg.sv
// Contract
// - writing 0x95 to write_lock unlocks, any other value relocks
// - output code updates are ignored while configuration is unlocked
// - error_force 0b01 sets error, 0b10 clears it, others do nothing
// - error_force field returns to zero by itself after acting
// - error state is active after power-on until something clears it
// - a valid received frame clears the error state
// - control bit 0 gives a full power-on reset, then clears itself; the code fifo keeps its contents, only rst_i clears it
// - with ack enable set, each valid frame is acknowledged on the line
// - enable bit 3 gates reporting of framing errors
// - enable bit 2 gates reporting of parity errors
// - enable bit 1 gates reporting of an inactive channel
// - enable bit 0 gates reporting of output loop faults
// - error only after threshold plus one consecutive bad frames
// - low band: error output code is low_band_code then zero byte
// - high band: error output code is high_band_code then zero byte
// - delimiter high time accepted between 7/16 and 9/16 of period
// - zero symbol high time accepted between 3/16 and 5/16 of period
// - one symbol high time accepted between 11/16 and 13/16 of period
// - fault and power-up put output in band chosen by a pin
// - each frame is checked for length and parity before acceptance
// - too little channel activity raises an error
package sdc_pkg;

	// register offsets
	localparam logic [7:0] ADDR_LOCK = 8'h00;
	localparam logic [7:0] ADDR_CTL = 8'h01;
	localparam logic [7:0] ADDR_EN = 8'h02;
	localparam logic [7:0] ADDR_THR = 8'h03;
	localparam logic [7:0] ADDR_LOW = 8'h04;
	localparam logic [7:0] ADDR_HIGH = 8'h05;

	// values after reset (RST_CTL is not loaded, reset clears the control fields), and the unlock code
	localparam logic [7:0] RST_LOCK = 8'h00;
	localparam logic [7:0] RST_CTL = 8'h08;
	localparam logic [7:0] RST_EN = 8'h1F;
	localparam logic [7:0] RST_THR = 8'h08;
	localparam logic [7:0] RST_LOW = 8'h24;
	localparam logic [7:0] RST_HIGH = 8'hE8;
	localparam logic [7:0] UNLOCK_CODE = 8'h95;

	// writable bits, reserved bits stored as zero
	localparam logic [7:0] CTL_WMASK = 8'h19;
	localparam logic [7:0] EN_WMASK = 8'h1F;
	localparam logic [7:0] THR_WMASK = 8'h0F;

	// field positions
	localparam int CTL_RST_BIT = 0;
	localparam int FORCE_LSB = 3;
	localparam int EN_ACK_BIT = 4;
	localparam int EN_FRAME_BIT = 3;
	localparam int EN_PARITY_BIT = 2;
	localparam int EN_CHAN_BIT = 1;
	localparam int EN_LOOP_BIT = 0;
	localparam logic [1:0] FORCE_SET = 2'h1;
	localparam logic [1:0] FORCE_CLR = 2'h2;

	// timing
	localparam int CLK_HZ = 125_000_000;
	localparam int CHAN_TIMEOUT_MS = 100;
	localparam int CHAN_TIMEOUT_CYC = CLK_HZ / 1000 * CHAN_TIMEOUT_MS;
	localparam int CNT_W = 20;
	localparam int PRD_W = 24;
	localparam int IDLE_W = 24;

	// duty windows in sixteenths of the symbol period
	localparam logic [23:0] DUTY_D_LO = 24'h7;
	localparam logic [23:0] DUTY_D_HI = 24'h9;
	localparam logic [23:0] DUTY_0_LO = 24'h3;
	localparam logic [23:0] DUTY_0_HI = 24'h5;
	localparam logic [23:0] DUTY_1_LO = 24'hB;
	localparam logic [23:0] DUTY_1_HI = 24'hD;

	// frame: kind bit, 16 payload bits, even parity bit
	localparam int FRAME_BITS = 18;
	localparam int CODE_W = 16;
	localparam int FIFO_DEPTH = 8;

	typedef enum logic [1:0] {
		SDC_SYM_BAD = 2'h0,
		SDC_SYM_ZERO = 2'h1,
		SDC_SYM_ONE = 2'h2,
		SDC_SYM_DELIM = 2'h3
	} sdc_sym_t;

	typedef enum logic [1:0] {
		SDC_ACK_IDLE = 2'h0,
		SDC_ACK_WAIT = 2'h1,
		SDC_ACK_HOLD = 2'h2
	} sdc_ack_t;

	// configuration registers travelling together
	typedef struct packed {
		logic [7:0] lock;
		logic [1:0] force_cmd;
		logic soft_rst;
		logic [7:0] en;
		logic [3:0] thr;
		logic [7:0] low;
		logic [7:0] high;
	} sdc_cfg_t;

endpackage

// ===== rtl/sdc_config_error_regs.sv
`timescale 1ns/1ps

// small synchronous fifo, registered output stage
module sdc_fifo #(
	parameter int W = 16,
	parameter int D = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	input wire logic [W-1:0] in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	output logic [W-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	localparam int CW = $clog2(D + 1);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [CW-1:0] cnt;
		logic ov;
		logic [W-1:0] od;
	} sdc_fifo_st_t;

	sdc_fifo_st_t s_r, s_nxt;
	logic push, pop;

	assign in_ready_o = (s_r.cnt != CW'(D));
	assign out_valid_o = s_r.ov;
	assign out_data_o = s_r.od;

	// pointer wrap kept explicit so depth need not be a power of two
	always_comb begin
		s_nxt = s_r;
		push = in_valid_i && in_ready_o;
		pop = (s_r.cnt != '0) && (!s_r.ov || out_ready_i);
		if (out_ready_i) begin
			s_nxt.ov = 1'b0;
		end
		if (push) begin
			s_nxt.mem[s_r.wp] = in_data_i;
			s_nxt.wp = (s_r.wp == AW'(D - 1)) ? '0 : s_r.wp + 1'b1;
		end
		if (pop) begin
			s_nxt.od = s_r.mem[s_r.rp];
			s_nxt.ov = 1'b1;
			s_nxt.rp = (s_r.rp == AW'(D - 1)) ? '0 : s_r.rp + 1'b1;
		end
		if (push && !pop) begin
			s_nxt.cnt = s_r.cnt + 1'b1;
		end else if (pop && !push) begin
			s_nxt.cnt = s_r.cnt - 1'b1;
		end
		if (rst_i) begin
			s_nxt = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		s_r <= s_nxt;
	end
endmodule // sdc_fifo

// configuration and error control behind the one-wire serial link
module sdc_config_error_regs #(
	parameter int TIMEOUT_CYC = sdc_pkg::CHAN_TIMEOUT_CYC,
	parameter int FIFO_DEPTH = sdc_pkg::FIFO_DEPTH
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic one_wire_serial_i,
	input wire logic fault_band_select_i,
	input wire logic loop_fault_i,
	output logic ack_pulse_n_o,
	output logic ack_pulse_n_oe_o,
	output logic fault_flag_n_o,
	output logic fault_flag_n_oe_o,
	output logic [sdc_pkg::CODE_W-1:0] output_code_o,
	output logic error_state_o,
	output logic code_valid_o,
	output logic [sdc_pkg::CODE_W-1:0] code_o,
	input wire logic code_ready_i
);
	localparam int CW = sdc_pkg::CNT_W;
	localparam int PW = sdc_pkg::PRD_W;
	localparam int IW = sdc_pkg::IDLE_W;

	typedef struct packed {
		logic din_m;
		logic din_s;
		logic din_d;
		logic band_m;
		logic band_s;
		logic loopf_m;
		logic loopf_s;
		logic [CW-1:0] hi_cnt;
		logic [CW-1:0] per_cnt;
		logic [CW-1:0] tp;
		logic [IW-1:0] idle_cnt;
		logic in_frame;
		logic [4:0] bit_cnt;
		logic [sdc_pkg::FRAME_BITS-1:0] shift;
		logic [4:0] err_run;
		sdc_pkg::sdc_cfg_t cfg;
		logic [sdc_pkg::CODE_W-1:0] data_code;
		logic err;
		logic [sdc_pkg::CODE_W-1:0] code;
		logic [sdc_pkg::CODE_W-1:0] sent;
		sdc_pkg::sdc_ack_t ack_st;
		logic [CW:0] ack_cnt;
		logic ack_oe;
		logic flag_oe;
	} sdc_st_t;

	sdc_st_t s_r, s_nxt;
	logic fifo_ready;
	logic rise, fall, frame_ok, frame_bad, parity_bad, idle_hit;
	logic unlocked, err_set, err_clr;
	sdc_pkg::sdc_sym_t sym;
	logic [7:0] wr_addr, wr_data;

	// duty check against the period measured on the previous symbol
	function automatic sdc_pkg::sdc_sym_t classify(
		input logic [CW-1:0] th,
		input logic [CW-1:0] tp
	);
		logic [PW-1:0] a;
		logic [PW-1:0] p;
		a = {th, 4'h0};
		p = {4'h0, tp};
		classify = sdc_pkg::SDC_SYM_BAD;
		if (tp == '0) begin
			classify = sdc_pkg::SDC_SYM_BAD;
		end else if (a >= p * sdc_pkg::DUTY_D_LO &&
				a <= p * sdc_pkg::DUTY_D_HI) begin
			classify = sdc_pkg::SDC_SYM_DELIM;
		end else if (a >= p * sdc_pkg::DUTY_0_LO &&
				a <= p * sdc_pkg::DUTY_0_HI) begin
			classify = sdc_pkg::SDC_SYM_ZERO;
		end else if (a >= p * sdc_pkg::DUTY_1_LO &&
				a <= p * sdc_pkg::DUTY_1_HI) begin
			classify = sdc_pkg::SDC_SYM_ONE;
		end
	endfunction

	// saturating increment, shared by the symbol timers
	function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v);
		sat_inc = (v == '1) ? v : v + 1'b1;
	endfunction

	sdc_fifo #(
		.W(sdc_pkg::CODE_W),
		.D(FIFO_DEPTH)
	) u_code_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_valid_i(s_r.code != s_r.sent),
		.in_data_i(s_r.code),
		.in_ready_o(fifo_ready),
		.out_valid_o(code_valid_o),
		.out_data_o(code_o),
		.out_ready_i(code_ready_i)
	);

	// pins: values tied to zero, enables low while pulling low
	assign ack_pulse_n_o = 1'b0;
	assign fault_flag_n_o = 1'b0;
	assign ack_pulse_n_oe_o = s_r.ack_oe;
	assign fault_flag_n_oe_o = s_r.flag_oe;
	assign output_code_o = s_r.code;
	assign error_state_o = s_r.err;

	always_comb begin
		s_nxt = s_r;
		frame_ok = 1'b0;
		frame_bad = 1'b0;
		parity_bad = 1'b0;
		err_set = 1'b0;
		err_clr = 1'b0;
		wr_addr = s_r.shift[16:9];
		wr_data = s_r.shift[8:1];
		unlocked = (s_r.cfg.lock == sdc_pkg::UNLOCK_CODE);

		// two-flop synchronisers; only the second stage feeds logic
		s_nxt.din_m = one_wire_serial_i;
		s_nxt.din_s = s_r.din_m;
		s_nxt.din_d = s_r.din_s;
		s_nxt.band_m = fault_band_select_i;
		s_nxt.band_s = s_r.band_m;
		s_nxt.loopf_m = loop_fault_i;
		s_nxt.loopf_s = s_r.loopf_m;
		rise = s_r.din_s && !s_r.din_d;
		fall = !s_r.din_s && s_r.din_d;

		// symbol timers track the master's rate every rising edge
		if (rise) begin
			s_nxt.tp = s_r.per_cnt;
			s_nxt.per_cnt = CW'(1);
			s_nxt.hi_cnt = CW'(1);
		end else begin
			s_nxt.per_cnt = sat_inc(s_r.per_cnt);
			if (s_r.din_s) begin
				s_nxt.hi_cnt = sat_inc(s_r.hi_cnt);
			end
		end

		// channel activity watchdog, one event per quiet spell
		idle_hit = 1'b0;
		if (rise) begin
			s_nxt.idle_cnt = '0;
		end else if (s_r.idle_cnt != IW'(TIMEOUT_CYC)) begin
			s_nxt.idle_cnt = s_r.idle_cnt + 1'b1;
			idle_hit = (s_r.idle_cnt == IW'(TIMEOUT_CYC - 1));
		end

		// frame assembly, judged at each falling edge
		sym = classify(s_r.hi_cnt, s_r.tp);
		if (fall) begin
			case (sym)
			sdc_pkg::SDC_SYM_DELIM: begin
				if (s_r.in_frame &&
						s_r.bit_cnt == 5'(sdc_pkg::FRAME_BITS)) begin
					if (^s_r.shift) begin
						parity_bad = 1'b1;
					end else begin
						frame_ok = 1'b1;
					end
				end else if (s_r.in_frame && s_r.bit_cnt != '0) begin
					frame_bad = 1'b1;
				end
				s_nxt.in_frame = 1'b1;
				s_nxt.bit_cnt = '0;
			end
			sdc_pkg::SDC_SYM_ZERO, sdc_pkg::SDC_SYM_ONE: begin
				if (s_r.in_frame &&
						s_r.bit_cnt != 5'(sdc_pkg::FRAME_BITS)) begin
					s_nxt.shift = {s_r.shift[sdc_pkg::FRAME_BITS-2:0],
						sym == sdc_pkg::SDC_SYM_ONE};
					s_nxt.bit_cnt = s_r.bit_cnt + 1'b1;
				end else if (s_r.in_frame) begin
					frame_bad = 1'b1;
					s_nxt.in_frame = 1'b0;
				end
			end
			default: begin
				frame_bad = s_r.in_frame && s_r.bit_cnt != '0;
				s_nxt.in_frame = 1'b0;
			end
			endcase
		end

		// run of consecutive reported faults against the threshold
		if (frame_ok) begin
			s_nxt.err_run = '0;
		end else if ((frame_bad && s_r.cfg.en[sdc_pkg::EN_FRAME_BIT]) ||
				(parity_bad && s_r.cfg.en[sdc_pkg::EN_PARITY_BIT])) begin
			if (s_r.err_run >= {1'b0, s_r.cfg.thr}) begin
				err_set = 1'b1;
				s_nxt.err_run = '0;
			end else begin
				s_nxt.err_run = s_r.err_run + 1'b1;
			end
		end

		// apply an accepted frame: data code or register write
		if (frame_ok) begin
			err_clr = 1'b1;
			if (!s_r.shift[sdc_pkg::FRAME_BITS-1]) begin
				if (!unlocked) begin
					s_nxt.data_code = s_r.shift[16:1];
				end
			end else if (wr_addr == sdc_pkg::ADDR_LOCK) begin
				s_nxt.cfg.lock = wr_data;
			end else if (unlocked) begin
				// reserved bits masked so stray ones cannot steer logic
				case (wr_addr)
				sdc_pkg::ADDR_CTL: begin
					s_nxt.cfg.force_cmd =
						wr_data[sdc_pkg::FORCE_LSB+1:sdc_pkg::FORCE_LSB];
					s_nxt.cfg.soft_rst = wr_data[sdc_pkg::CTL_RST_BIT];
				end
				sdc_pkg::ADDR_EN: s_nxt.cfg.en = wr_data & sdc_pkg::EN_WMASK;
				sdc_pkg::ADDR_THR: s_nxt.cfg.thr = wr_data[3:0];
				sdc_pkg::ADDR_LOW: s_nxt.cfg.low = wr_data;
				sdc_pkg::ADDR_HIGH: s_nxt.cfg.high = wr_data;
				default: s_nxt.cfg = s_r.cfg;
				endcase
			end
		end

		// software force acts once, then the field empties itself
		if (s_r.cfg.force_cmd == sdc_pkg::FORCE_SET) begin
			err_set = 1'b1;
		end else if (s_r.cfg.force_cmd == sdc_pkg::FORCE_CLR) begin
			err_clr = 1'b1;
		end
		if (s_r.cfg.force_cmd != '0) begin
			s_nxt.cfg.force_cmd = '0;
		end

		// hardware faults, each behind its enable
		if (idle_hit && s_r.cfg.en[sdc_pkg::EN_CHAN_BIT]) begin
			err_set = 1'b1;
		end
		if (s_r.loopf_s && s_r.cfg.en[sdc_pkg::EN_LOOP_BIT]) begin
			err_set = 1'b1;
		end

		// a set in the same cycle as a clear wins
		if (err_set) begin
			s_nxt.err = 1'b1;
		end else if (err_clr) begin
			s_nxt.err = 1'b0;
		end

		// error band replaces the data code while the error stands
		if (s_r.err) begin
			s_nxt.code = s_r.band_s ?
				{s_r.cfg.high, 8'h00} :
				{s_r.cfg.low, 8'h00};
		end else begin
			s_nxt.code = s_r.data_code;
		end
		// converter back-pressure: latest code is offered until taken
		if (s_r.code != s_r.sent && fifo_ready) begin
			s_nxt.sent = s_r.code;
		end

		s_nxt.flag_oe = !s_r.err;

		// acknowledge: wait a quarter period, then hold one and a half
		case (s_r.ack_st)
		sdc_pkg::SDC_ACK_IDLE: begin
			s_nxt.ack_oe = 1'b1;
			if (frame_ok && s_r.cfg.en[sdc_pkg::EN_ACK_BIT]) begin
				s_nxt.ack_st = sdc_pkg::SDC_ACK_WAIT;
				s_nxt.ack_cnt = {3'h0, s_r.tp[CW-1:2]};
			end
		end
		sdc_pkg::SDC_ACK_WAIT: begin
			if (s_r.ack_cnt == '0) begin
				s_nxt.ack_st = sdc_pkg::SDC_ACK_HOLD;
				s_nxt.ack_oe = 1'b0;
				s_nxt.ack_cnt = {1'b0, s_r.tp} + {2'h0, s_r.tp[CW-1:1]};
			end else begin
				s_nxt.ack_cnt = s_r.ack_cnt - 1'b1;
			end
		end
		sdc_pkg::SDC_ACK_HOLD: begin
			if (s_r.ack_cnt == '0) begin
				s_nxt.ack_st = sdc_pkg::SDC_ACK_IDLE;
				s_nxt.ack_oe = 1'b1;
			end else begin
				s_nxt.ack_cnt = s_r.ack_cnt - 1'b1;
			end
		end
		default: begin
			s_nxt.ack_st = sdc_pkg::SDC_ACK_IDLE;
			s_nxt.ack_oe = 1'b1;
		end
		endcase

		// pin reset and the soft reset bit restore the same defaults
		if (rst_i || s_r.cfg.soft_rst) begin
			s_nxt = '0;
			s_nxt.cfg.lock = sdc_pkg::RST_LOCK;
			s_nxt.cfg.en = sdc_pkg::RST_EN;
			s_nxt.cfg.thr = sdc_pkg::RST_THR[3:0];
			s_nxt.cfg.low = sdc_pkg::RST_LOW;
			s_nxt.cfg.high = sdc_pkg::RST_HIGH;
			s_nxt.err = 1'b1;
			s_nxt.ack_oe = 1'b1;
			s_nxt.flag_oe = 1'b1;
			s_nxt.ack_st = sdc_pkg::SDC_ACK_IDLE;
		end
	end

	always_ff @(posedge clk_i) begin
		s_r <= s_nxt;
	end
endmodule // sdc_config_error_regs

// ===== tb/sdc_master_model.sv
`timescale 1ns/1ps

// master end of the one-wire link; symbols start on a clock edge
module sdc_master_model #(
	parameter int TP = 64
) (
	input wire logic clk_i,
	input wire logic ack_n_i,
	output logic line_o
);
	logic seen = 1'b0;

	// line idles low and holds it between frames
	initial line_o = 1'b0;

	// sticky acknowledge seen on the pulled-up wire
	always @(posedge clk_i) begin
		if (ack_n_i === 1'b0)
			seen <= 1'b1;
	end

	// one symbol: high for h clocks, low for the rest of the period
	task automatic sym(input int h);
		line_o <= 1'b1;
		repeat (h) @(posedge clk_i);
		line_o <= 1'b0;
		repeat (TP - h) @(posedge clk_i);
	endtask

	// two delimiters after idle, the first has no period reference
	task automatic lead();
		sym(TP / 2);
		sym(TP / 2);
	endtask

	// bits msb first, even parity, closing delimiter shared with next
	task automatic frame(input logic [16:0] kp, input int bad,
		output logic ack);
		logic p;
		p = ^kp ^ (bad == 1);
		for (int i = 16; i >= 0; i--)
			sym(kp[i] ? TP * 3 / 4 : TP / 4);
		sym(bad == 2 ? TP / 8 : (p ? TP * 3 / 4 : TP / 4));
		seen = 1'b0;
		sym(TP / 2);
		ack = seen;
	endtask
endmodule // sdc_master_model

// ===== tb/sdc_config_error_regs_chk.sv
`timescale 1ns/1ps

// port-level checks on the register bank
module sdc_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic one_wire_serial_i,
	input wire logic ack_pulse_n_o,
	input wire logic ack_pulse_n_oe_o,
	input wire logic fault_flag_n_o,
	input wire logic fault_flag_n_oe_o,
	input wire logic [15:0] output_code_o,
	input wire logic error_state_o,
	input wire logic code_valid_o,
	input wire logic [15:0] code_o,
	input wire logic code_ready_i
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// flag pin follows the error state one edge late
	property p_flag;
		!$past(rst_i) |-> fault_flag_n_oe_o == !$past(error_state_o);
	endproperty
	a_flag: assert property (p_flag) else $error("flag mismatch");

	// open-drain pins only ever pull low
	property p_od;
		ack_pulse_n_o == 1'b0 && fault_flag_n_o == 1'b0;
	endproperty
	a_od: assert property (p_od) else $error("od value");

	// error code has a zero lower byte
	property p_low;
		$past(error_state_o) && !$past(rst_i) |-> output_code_o[7:0] == 8'h00;
	endproperty
	a_low: assert property (p_low) else $error("low byte");

	// state just after reset
	property p_reset;
		$past(rst_i) |-> error_state_o && !code_valid_o && fault_flag_n_oe_o;
	endproperty
	a_reset: assert property (p_reset) else $error("reset state");

	// acknowledge is a held pulse, not a glitch
	property p_ack_hold;
		$fell(ack_pulse_n_oe_o) |=> !ack_pulse_n_oe_o [*8];
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("ack cut");

	// acknowledge starts only while the master holds the line low
	property p_ack_quiet;
		$fell(ack_pulse_n_oe_o) |-> !one_wire_serial_i;
	endproperty
	a_ack_quiet: assert property (p_ack_quiet) else $error("early");

	// a stalled word stands
	property p_hold;
		code_valid_o && !code_ready_i |=> code_valid_o && $stable(code_o);
	endproperty
	a_hold: assert property (p_hold) else $error("fifo word moved");

	// a change of output code is followed within 1 to 6 cycles by a valid fifo output
	property p_push;
		$changed(output_code_o) && !$past(rst_i) |-> ##[1:6] code_valid_o;
	endproperty
	a_push: assert property (p_push) else $error("code not queued");

	c_clear: cover property ($fell(error_state_o));
	c_ack: cover property ($fell(ack_pulse_n_oe_o));
	c_stall: cover property (code_valid_o && !code_ready_i);
endmodule // sdc_chk

bind sdc_config_error_regs sdc_chk chk_i (.clk_i(clk_i), .rst_i(rst_i),
	.one_wire_serial_i(one_wire_serial_i), .ack_pulse_n_o(ack_pulse_n_o),
	.ack_pulse_n_oe_o(ack_pulse_n_oe_o), .fault_flag_n_o(fault_flag_n_o),
	.fault_flag_n_oe_o(fault_flag_n_oe_o), .output_code_o(output_code_o),
	.error_state_o(error_state_o), .code_valid_o(code_valid_o),
	.code_o(code_o), .code_ready_i(code_ready_i));

// ===== tb/sdc_config_error_regs_tb.sv
`timescale 1ns/1ps

// bench: frames from the master model, checks at the outputs
module sdc_config_error_regs_tb;
	localparam int TP = 64;
	localparam int TMO = 3000;
	localparam int LIMIT = 90000;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic band = 1'b0;
	logic loop_f = 1'b0;
	logic ready = 1'b1;
	logic line, ack_n, ack_oe, flag_n, flag_oe, err, vld, ak, ack_w;
	logic [15:0] code, fcode;
	int errors = 0;
	int checks = 0;
	int cyc = 0;
	int n;

	// pulled-up acknowledge wire
	assign ack_w = ack_oe ? 1'b1 : ack_n;

	sdc_config_error_regs #(.TIMEOUT_CYC(TMO), .FIFO_DEPTH(8))
		sdc_config_error_regs_i (.clk_i(clk_i), .rst_i(rst_i),
		.one_wire_serial_i(line), .fault_band_select_i(band),
		.loop_fault_i(loop_f), .ack_pulse_n_o(ack_n),
		.ack_pulse_n_oe_o(ack_oe), .fault_flag_n_o(flag_n),
		.fault_flag_n_oe_o(flag_oe), .output_code_o(code),
		.error_state_o(err), .code_valid_o(vld), .code_o(fcode),
		.code_ready_i(ready));

	sdc_master_model #(.TP(TP)) sdc_master_model_i (.clk_i(clk_i),
		.ack_n_i(ack_w), .line_o(line));

	// 8 ns clock
	always #4 clk_i = ~clk_i;

	task automatic chk_bit(input logic g, input logic e);
		checks++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %0t bit %b exp %b", $time, g, e);
		end
	endtask

	task automatic chk_code(input logic [15:0] g, input logic [15:0] e);
		checks++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %0t code %h exp %h", $time, g, e);
		end
	endtask

	// register write; reserved bits always sent as zero
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sdc_master_model_i.frame({1'b1, a, d}, 0, ak);
	endtask

	task automatic dat(input logic [15:0] c, input int bad);
		sdc_master_model_i.frame({1'b0, c}, bad, ak);
	endtask

	// quiet line, then fresh delimiters
	task automatic idle(input int c);
		repeat (c) @(posedge clk_i);
		sdc_master_model_i.lead();
	endtask

	task automatic finish_test();
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// hang guard
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == LIMIT) begin
			errors++;
			$display("[ERR] %0t timeout", $time);
			finish_test();
		end
	end

	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (20) @(posedge clk_i);
		chk_bit(err, 1'b1);
		chk_code(code, 16'h2400);
		// stall the sink, toggle the band to fill the buffer
		ready <= 1'b0;
		for (int i = 0; i < 12; i++) begin
			band <= ~band;
			repeat (12) @(posedge clk_i);
			if (i == 0)
				chk_code(code, 16'hE800);
		end
		ready <= 1'b1;
		n = 0;
		repeat (40) begin
			@(negedge clk_i);
			if (vld === 1'b1) begin
				chk_code(fcode, n % 2 ? 16'h2400 : 16'hE800);
				n++;
			end
		end
		chk_bit(n == 10, 1'b1);
		idle(1);
		dat(16'h1234, 0);
		chk_bit(err, 1'b0);
		chk_code(code, 16'h1234);
		chk_bit(ak, 1'b1);
		wr(8'h00, 8'h95);
		dat(16'h5678, 0);
		chk_code(code, 16'h1234);
		wr(8'h03, 8'h01);
		wr(8'h04, 8'h31);
		wr(8'h01, 8'h08);
		chk_bit(err, 1'b1);
		chk_code(code, 16'h3100);
		// patterns 0b11 and 0b10 must not raise the error again
		wr(8'h01, 8'h18);
		chk_bit(err, 1'b0);
		wr(8'h01, 8'h10);
		chk_bit(err, 1'b0);
		wr(8'h00, 8'h00);
		chk_bit(err, 1'b0);
		chk_code(code, 16'h1234);
		wr(8'h03, 8'h00);
		dat(16'h1111, 1);
		chk_bit(err, 1'b0);
		dat(16'h2222, 2);
		chk_bit(err, 1'b1);
		dat(16'h4000, 0);
		wr(8'h00, 8'h95);
		wr(8'h02, 8'h02);
		wr(8'h00, 8'h00);
		dat(16'h3333, 1);
		dat(16'h3333, 2);
		dat(16'h3333, 1);
		chk_bit(err, 1'b0);
		dat(16'h4321, 0);
		chk_bit(ak, 1'b0);
		chk_code(code, 16'h4321);
		loop_f <= 1'b1;
		repeat (10) @(posedge clk_i);
		chk_bit(err, 1'b0);
		loop_f <= 1'b0;
		repeat (TMO + 200) @(posedge clk_i);
		chk_bit(err, 1'b1);
		idle(0);
		dat(16'h4321, 0);
		wr(8'h00, 8'h95);
		wr(8'h02, 8'h01);
		wr(8'h00, 8'h00);
		loop_f <= 1'b1;
		idle(10);
		chk_bit(err, 1'b1);
		loop_f <= 1'b0;
		idle(5);
		dat(16'h4321, 0);
		chk_bit(err, 1'b0);
		repeat (TMO + 200) @(posedge clk_i);
		chk_bit(err, 1'b0);
		// soft reset restores defaults, lock included
		idle(0);
		wr(8'h00, 8'h95);
		wr(8'h01, 8'h01);
		chk_bit(err, 1'b1);
		chk_code(code, 16'h2400);
		idle(0);
		dat(16'h7777, 0);
		chk_code(code, 16'h7777);
		chk_bit(ak, 1'b1);
		finish_test();
	end
endmodule // sdc_config_error_regs_tb
